// ==== rtl/stop_reaction_regs.svh ====
// Register indices, reset values and mode codes of the stop reaction selector.
`ifndef STOP_REACTION_REGS_SVH
`define STOP_REACTION_REGS_SVH

// Register indices; the byte address is four times the index.
`define IDX_QUICK_STOP_CODE 16'h605a
`define IDX_SHUTDOWN_CODE   16'h605b
`define IDX_DISABLE_CODE    16'h605c
`define IDX_HALT_CODE       16'h605d
`define IDX_FAULT_CODE      16'h605e
`define IDX_VL_SLOW_SPEED   16'h7000
`define IDX_VL_SLOW_TIME    16'h7001
`define IDX_VL_QUICK_SPEED  16'h7002
`define IDX_VL_QUICK_TIME   16'h7003
`define IDX_STATUS          16'h7004

// Reset values.
`define RST_QUICK_STOP_CODE 16'h0001
`define RST_SHUTDOWN_CODE   16'h0001
`define RST_DISABLE_CODE    16'h0001
`define RST_HALT_CODE       16'h0001
`define RST_FAULT_CODE      16'h0002
`define RST_VL_SLOW_SPEED   32'h000001f4
`define RST_VL_SLOW_TIME    16'h0001
`define RST_VL_QUICK_SPEED  32'h00001388
`define RST_VL_QUICK_TIME   16'h0001

// Option code values and the velocity mode code.
`define CODE_IMMEDIATE      16'h0000
`define CODE_SLOW_RAMP      16'h0001
`define CODE_QUICK_RAMP     16'h0002
`define MODE_VELOCITY       8'h02

// Status register fields.
`define ST_REJECT_BIT       0
`define ST_KIND_LSB         4
`define ST_TO_DISABLED_BIT  8

`endif

// ==== rtl/stop_reaction_pkg.sv ====
// Types shared by the stop reaction selector and its bench.
package stop_reaction_pkg;

  typedef enum logic [1:0] {
    STOP_NONE,
    STOP_IMMEDIATE,
    STOP_SLOW_RAMP,
    STOP_QUICK_RAMP
  } stop_kind_t;

  typedef struct packed {
    logic       go;
    stop_kind_t kind;
    logic       to_disabled;
    logic [31:0] decel_speed;
    logic [15:0] decel_time;
  } reaction_t;

  typedef struct packed {
    logic       quick_stop;
    logic       shutdown;
    logic       disable_op;
    logic       fault;
  } psm_events_t;

endpackage

// ==== rtl/stop_reaction_selector.sv ====
// Stop reaction selector: option code registers and stop decision logic.
`timescale 1ns/100ps
`include "stop_reaction_regs.svh"

module stop_reaction_selector (
  input  wire logic                             hclk,
  input  wire logic                             hresetn,
  input  wire logic                             hsel,
  input  wire logic [31:0]                      haddr,
  input  wire logic [1:0]                       htrans,
  input  wire logic                             hwrite,
  input  wire logic [2:0]                       hsize,
  input  wire logic [31:0]                      hwdata,
  input  wire logic                             hready,
  output logic [31:0]                           hrdata,
  output logic                                  hreadyout,
  output logic                                  hresp,
  input  wire stop_reaction_pkg::psm_events_t   events,
  input  wire logic                             halt_bit,
  input  wire logic [7:0]                       active_mode,
  input  wire logic [31:0]                      mode_slow_speed,
  input  wire logic [15:0]                      mode_slow_time,
  input  wire logic [31:0]                      mode_quick_speed,
  input  wire logic [15:0]                      mode_quick_time,
  output stop_reaction_pkg::reaction_t          reaction
);
  import stop_reaction_pkg::*;

  typedef struct packed {
    logic        wr_pend;
    logic [15:0] wr_idx;
    logic [31:0] rdata;
    logic [15:0] qs_code;
    logic [15:0] sd_code;
    logic [15:0] dis_code;
    logic [15:0] halt_code;
    logic [15:0] fault_code;
    logic [31:0] vl_slow_speed;
    logic [15:0] vl_slow_time;
    logic [31:0] vl_quick_speed;
    logic [15:0] vl_quick_time;
    logic        reject;
    logic        halt_prev;
    reaction_t   react;
  } state_t;

  state_t s_q;
  state_t s_d;

  function automatic logic [31:0] read_reg(input state_t s,
                                           input logic [15:0] idx);
    logic [31:0] v;
    v = 32'h00000000;
    case (idx)
      `IDX_QUICK_STOP_CODE: v = {16'h0000, s.qs_code};
      `IDX_SHUTDOWN_CODE:   v = {16'h0000, s.sd_code};
      `IDX_DISABLE_CODE:    v = {16'h0000, s.dis_code};
      `IDX_HALT_CODE:       v = {16'h0000, s.halt_code};
      `IDX_FAULT_CODE:      v = {16'h0000, s.fault_code};
      `IDX_VL_SLOW_SPEED:   v = s.vl_slow_speed;
      `IDX_VL_SLOW_TIME:    v = {16'h0000, s.vl_slow_time};
      `IDX_VL_QUICK_SPEED:  v = s.vl_quick_speed;
      `IDX_VL_QUICK_TIME:   v = {16'h0000, s.vl_quick_time};
      `IDX_STATUS: begin
        v[`ST_REJECT_BIT] = s.reject;
        v[`ST_KIND_LSB +: 2] = s.react.kind;
        v[`ST_TO_DISABLED_BIT] = s.react.to_disabled;
      end
      default: v = 32'h00000000;
    endcase
    return v;
  endfunction

  logic        addr_ok;
  logic        take;
  logic        code_ok;
  logic        vl_mode;
  logic        halt_rise;
  logic        halt_fall;
  logic [15:0] wcode;
  logic [15:0] sel_code;
  stop_kind_t  kind;
  logic        to_dis;
  logic        fire;

  always_comb begin
    s_d = s_q;
    wcode = hwdata[15:0];
    code_ok = 1'b1;
    // Unmapped or unaligned addresses read as zero and store no write data; a write to an unmapped aligned index still clears the reject bit.
    addr_ok = (haddr[31:18] == 14'h0000) && (haddr[1:0] == 2'b00);
    take = hsel && hready && htrans[1];
    vl_mode = (active_mode == `MODE_VELOCITY);
    halt_rise = halt_bit && !s_q.halt_prev;
    halt_fall = !halt_bit && s_q.halt_prev;
    sel_code = `CODE_IMMEDIATE;
    kind = STOP_NONE;
    to_dis = 1'b0;
    fire = 1'b0;

    // Data phase of a write: the code is checked before it is stored.
    if (s_q.wr_pend) begin
      case (s_q.wr_idx)
        `IDX_QUICK_STOP_CODE: begin
          code_ok = (wcode <= `CODE_QUICK_RAMP);
          if (code_ok) s_d.qs_code = wcode;
        end
        `IDX_SHUTDOWN_CODE: begin
          code_ok = (wcode <= `CODE_SLOW_RAMP);
          if (code_ok) s_d.sd_code = wcode;
        end
        `IDX_DISABLE_CODE: begin
          code_ok = (wcode <= `CODE_SLOW_RAMP);
          if (code_ok) s_d.dis_code = wcode;
        end
        `IDX_HALT_CODE: begin
          code_ok = (wcode == `CODE_SLOW_RAMP) ||
                    (wcode == `CODE_QUICK_RAMP);
          if (code_ok) s_d.halt_code = wcode;
        end
        `IDX_FAULT_CODE: begin
          code_ok = (wcode <= `CODE_QUICK_RAMP);
          if (code_ok) s_d.fault_code = wcode;
        end
        `IDX_VL_SLOW_SPEED:  s_d.vl_slow_speed = hwdata;
        `IDX_VL_SLOW_TIME:   s_d.vl_slow_time = hwdata[15:0];
        `IDX_VL_QUICK_SPEED: s_d.vl_quick_speed = hwdata;
        `IDX_VL_QUICK_TIME:  s_d.vl_quick_time = hwdata[15:0];
        default: code_ok = 1'b1;
      endcase
      s_d.reject = !code_ok;
    end

    s_d.wr_pend = take && hwrite && addr_ok;
    s_d.wr_idx = haddr[17:2];
    // Reads see a write in its data phase, so back-to-back access is safe.
    if (take && !hwrite && addr_ok) begin
      s_d.rdata = read_reg(s_d, haddr[17:2]);
    end else begin
      s_d.rdata = 32'h00000000;
    end

    // Fault outranks quick stop, which outranks the two transitions and halt.
    if (events.fault) begin
      sel_code = s_q.fault_code;
      fire = 1'b1;
    end else if (events.quick_stop) begin
      sel_code = s_q.qs_code;
      to_dis = (s_q.qs_code != `CODE_IMMEDIATE);
      fire = 1'b1;
    end else if (events.shutdown) begin
      sel_code = s_q.sd_code;
      to_dis = (s_q.sd_code == `CODE_SLOW_RAMP);
      fire = 1'b1;
    end else if (events.disable_op) begin
      sel_code = s_q.dis_code;
      to_dis = (s_q.dis_code == `CODE_SLOW_RAMP);
      fire = 1'b1;
    end else if (halt_rise) begin
      sel_code = s_q.halt_code;
      fire = 1'b1;
    end

    case (sel_code)
      `CODE_IMMEDIATE:  kind = STOP_IMMEDIATE;
      `CODE_SLOW_RAMP:  kind = STOP_SLOW_RAMP;
      `CODE_QUICK_RAMP: kind = STOP_QUICK_RAMP;
      default:          kind = STOP_NONE;
    endcase

    s_d.halt_prev = halt_bit;
    s_d.react.go = fire || halt_fall;
    if (fire) begin
      s_d.react.kind = kind;
      s_d.react.to_disabled = to_dis;
      case (kind)
        STOP_SLOW_RAMP: begin
          s_d.react.decel_speed = vl_mode ? s_q.vl_slow_speed
                                          : mode_slow_speed;
          s_d.react.decel_time = vl_mode ? s_q.vl_slow_time
                                         : mode_slow_time;
        end
        STOP_QUICK_RAMP: begin
          s_d.react.decel_speed = vl_mode ? s_q.vl_quick_speed
                                          : mode_quick_speed;
          s_d.react.decel_time = vl_mode ? s_q.vl_quick_time
                                         : mode_quick_time;
        end
        default: begin
          s_d.react.decel_speed = 32'h00000000;
          s_d.react.decel_time = 16'h0000;
        end
      endcase
    end else if (halt_fall) begin
      // Releasing halt withdraws the halt reaction and lets motion resume.
      s_d.react.kind = STOP_NONE;
      s_d.react.to_disabled = 1'b0;
      s_d.react.decel_speed = 32'h00000000;
      s_d.react.decel_time = 16'h0000;
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      s_q <= '0;
      s_q.qs_code <= `RST_QUICK_STOP_CODE;
      s_q.sd_code <= `RST_SHUTDOWN_CODE;
      s_q.dis_code <= `RST_DISABLE_CODE;
      s_q.halt_code <= `RST_HALT_CODE;
      s_q.fault_code <= `RST_FAULT_CODE;
      s_q.vl_slow_speed <= `RST_VL_SLOW_SPEED;
      s_q.vl_slow_time <= `RST_VL_SLOW_TIME;
      s_q.vl_quick_speed <= `RST_VL_QUICK_SPEED;
      s_q.vl_quick_time <= `RST_VL_QUICK_TIME;
      s_q.react.kind <= STOP_NONE;
    end else begin
      s_q <= s_d;
    end
  end

  assign hrdata = s_q.rdata;
  assign hreadyout = 1'b1;
  assign hresp = 1'b0;
  assign reaction = s_q.react;

endmodule

// ==== sim/stop_reaction_properties.sv ====
// Checker for the selector's bus answer and its stop reactions.
`timescale 1ns/100ps
module stop_reaction_checker
  import stop_reaction_pkg::*;
(
  input wire logic                           hclk,
  input wire logic                           hresetn,
  input wire logic                           hreadyout,
  input wire logic                           hresp,
  input wire logic                           halt_bit,
  input wire stop_reaction_pkg::psm_events_t events,
  input wire stop_reaction_pkg::reaction_t   reaction
);
  default clocking @(posedge hclk); endclocking
  default disable iff (!hresetn);
  a_bus_okay: assert property (hreadyout && !hresp)
    else $error("bus answer not zero-wait okay");
  a_event_go: assert property (events != '0 |=> reaction.go)
    else $error("event gave no go");
  a_go_cause: assert property (reaction.go |->
    $past(events) != '0 || $past(halt_bit) != $past(halt_bit, 2))
    else $error("go without cause");
  a_fault_stay: assert property (events.fault |=>
    !reaction.to_disabled && reaction.kind != STOP_NONE)
    else $error("fault reaction wrong");
  a_halt_brake: assert property ($rose(halt_bit) && events == '0 |=>
    reaction.go && reaction.kind inside {STOP_SLOW_RAMP, STOP_QUICK_RAMP})
    else $error("halt gave no brake");
  a_quick_off: assert property (events.quick_stop && !events.fault |=>
    reaction.to_disabled == (reaction.kind != STOP_IMMEDIATE))
    else $error("quick stop follow-up state wrong");
  a_fields_hold: assert property (!reaction.go |->
    $stable(reaction.kind) && $stable(reaction.to_disabled))
    else $error("reaction changed without go");
  a_immed_zero: assert property (reaction.kind == STOP_IMMEDIATE |->
    reaction.decel_speed == 0 && reaction.decel_time == 0)
    else $error("immediate stop carries a ramp");
  c_fault: cover property (events.fault);
  c_halt: cover property ($rose(halt_bit));
  c_quick: cover property (reaction.go && reaction.kind == STOP_QUICK_RAMP);
endmodule

bind stop_reaction_selector stop_reaction_checker u_chk (.hclk, .hresetn,
  .hreadyout, .hresp, .halt_bit, .events, .reaction);

// ==== sim/ahb_master_model.sv ====
// Bus master model standing in for the fieldbus side.
`timescale 1ns/100ps
module ahb_master_model (
  input  wire logic        hclk,
  input  wire logic        hready,
  input  wire logic [31:0] hrdata,
  output logic             hsel,
  output logic [31:0]      haddr,
  output logic [1:0]       htrans,
  output logic             hwrite,
  output logic [2:0]       hsize,
  output logic [31:0]      hwdata
);
  initial begin
    {hsel, haddr, htrans, hwrite, hwdata} = '0;
    hsize = 3'h2;
  end
  // Bounded so a stuck slave ends the run instead of hanging it.
  task automatic wait_ready();
    int n;
    n = 0;
    @(posedge hclk);
    while (hready !== 1'b1) begin
      n++;
      if (n > 20) tb_top.hang();
      @(posedge hclk);
    end
  endtask
  task automatic xfer(input logic w, input logic [15:0] idx,
                      input logic [31:0] wd, output logic [31:0] rd);
    hsel <= 1'b1;
    haddr <= {14'h0000, idx, 2'b00};
    htrans <= 2'b10;
    hwrite <= w;
    wait_ready();
    hsel <= 1'b0;
    htrans <= 2'b00;
    hwdata <= wd;
    wait_ready();
    rd = hrdata;
  endtask
endmodule

// ==== sim/tb_top.sv ====
// Bench driving the selector through its bus and stop events.
`timescale 1ns/100ps
`include "stop_reaction_regs.svh"
module tb_top;
  import stop_reaction_pkg::*;
  logic        hclk, hresetn, hsel, hwrite, hreadyout, hresp, halt_bit;
  logic [31:0] haddr, hwdata, hrdata, rd, mode_slow_speed, mode_quick_speed;
  logic [31:0] vl_qs;
  logic [15:0] mode_slow_time, mode_quick_time, vl_qt;
  logic [1:0]  htrans;
  logic [2:0]  hsize;
  logic [7:0]  active_mode;
  psm_events_t events;
  reaction_t   reaction;
  int          errors, n_tests;

  stop_reaction_selector u_dut (.hclk, .hresetn, .hsel, .haddr, .htrans,
    .hwrite, .hsize, .hwdata, .hready(hreadyout), .hrdata, .hreadyout, .hresp,
    .events, .halt_bit, .active_mode, .mode_slow_speed, .mode_slow_time,
    .mode_quick_speed, .mode_quick_time, .reaction);
  ahb_master_model u_bus (.hclk, .hready(hreadyout), .hrdata, .hsel, .haddr,
    .htrans, .hwrite, .hsize, .hwdata);

  initial begin
    hclk = 1'b0;
    forever #2 hclk = ~hclk;
  end

  task automatic give_verdict();
    $display("comparisons %0d, mismatches %0d", n_tests, errors);
    if (errors == 0 && n_tests > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask
  task automatic hang();
    errors++;
    $display("unexpected at %0t: wait ran out", $time);
    give_verdict();
  endtask
  task automatic chk(input logic [51:0] got, exp);
    n_tests++;
    if (got !== exp) begin
      errors++;
      $display("unexpected at %0t: got %h not %h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [15:0] idx, input logic [31:0] d);
    u_bus.xfer(1'b1, idx, d, rd);
  endtask
  task automatic rd_chk(input logic [15:0] idx, input logic [31:0] e);
    u_bus.xfer(1'b0, idx, 32'h0, rd);
    chk(52'(rd), 52'(e));
  endtask
  function automatic reaction_t want(input logic [1:0] c, input logic td);
    reaction_t r;
    logic      v;
    r = '0;
    v = active_mode == `MODE_VELOCITY;
    r.go = 1'b1;
    r.kind = stop_kind_t'(c + 2'd1);
    r.to_disabled = td;
    if (r.kind == STOP_SLOW_RAMP)
      r[47:0] = v ? {`RST_VL_SLOW_SPEED, `RST_VL_SLOW_TIME}
                  : {mode_slow_speed, mode_slow_time};
    if (r.kind == STOP_QUICK_RAMP)
      r[47:0] = v ? {vl_qs, vl_qt}
                  : {mode_quick_speed, mode_quick_time};
    return r;
  endfunction
  // The event is seen at one edge; the reaction is judged 1 ns after that same edge.
  task automatic fire(input psm_events_t ev, input logic h,
                      input reaction_t e);
    events <= ev;
    halt_bit <= h;
    @(posedge hclk);
    events <= '0;
    #1;
    chk(reaction, e);
    @(posedge hclk);
  endtask

  task automatic t_reset();
    for (int i = 0; i < 5; i++)
      rd_chk(`IDX_QUICK_STOP_CODE + 16'(i), i == 4 ? 32'h2 : 32'h1);
    rd_chk(`IDX_VL_QUICK_SPEED, `RST_VL_QUICK_SPEED);
    rd_chk(16'h6000, 32'h0);
    chk(reaction, '0);
    $display("reset values test done");
  endtask
  task automatic t_table();
    logic [7:0] t [12] = '{8'h00, 8'h01, 8'h02, 8'h10, 8'h11, 8'h20,
                           8'h21, 8'h31, 8'h32, 8'h40, 8'h41, 8'h42};
    logic [3:0] s;
    logic [1:0] c;
    foreach (t[i]) begin
      s = t[i][7:4];
      c = t[i][1:0];
      wr(`IDX_QUICK_STOP_CODE + 16'(s), 32'(c));
      if (s == 4'h3) begin
        fire('0, 1'b1, want(c, 1'b0));
        fire('0, 1'b0, want(2'h3, 1'b0));
      end else
        fire(psm_events_t'(s == 4'h4 ? 4'h1 : 4'h8 >> s), 1'b0,
             want(c, s < 4'h3 && c != 2'h0));
    end
    $display("option code test done");
  endtask
  task automatic t_modes();
    active_mode <= `MODE_VELOCITY;
    vl_qs = 32'h0000abcd;
    vl_qt = 16'h0007;
    wr(`IDX_VL_QUICK_SPEED, vl_qs);
    wr(`IDX_VL_QUICK_TIME, 32'(vl_qt));
    fire(4'h1, 1'b0, want(2'h2, 1'b0));
    fire(4'h2, 1'b0, want(2'h1, 1'b1));
    // Slow ramp kind in bits 5:4 and the follow-up state in bit 8.
    rd_chk(`IDX_STATUS, 32'h00000120);
    active_mode <= 8'h01;
    mode_slow_speed <= 32'h00000333;
    @(posedge hclk);
    fire(4'h2, 1'b0, want(2'h1, 1'b1));
    fire(4'h9, 1'b0, want(2'h2, 1'b0));
    $display("control mode test done");
  endtask
  task automatic t_reserved();
    wr(`IDX_QUICK_STOP_CODE, 32'h3);
    rd_chk(`IDX_QUICK_STOP_CODE, 32'h2);
    // Last reaction was a fault on the quick-stop ramp, so kind reads 3.
    rd_chk(`IDX_STATUS, 32'h00000031);
    wr(`IDX_SHUTDOWN_CODE, 32'h8000);
    rd_chk(`IDX_SHUTDOWN_CODE, 32'h1);
    wr(`IDX_HALT_CODE, 32'h0);
    rd_chk(`IDX_HALT_CODE, 32'h2);
    wr(`IDX_FAULT_CODE, 32'h0);
    rd_chk(`IDX_FAULT_CODE, 32'h0);
    rd_chk(`IDX_STATUS, 32'h00000030);
    $display("reserved code test done");
  endtask

  initial begin
    errors = 0;
    n_tests = 0;
    hresetn = 1'b0;
    events = '0;
    halt_bit = 1'b0;
    active_mode = 8'h01;
    mode_slow_speed = 32'h00000111;
    mode_slow_time = 16'h0003;
    mode_quick_speed = 32'h00000222;
    mode_quick_time = 16'h0005;
    vl_qs = `RST_VL_QUICK_SPEED;
    vl_qt = `RST_VL_QUICK_TIME;
    repeat (6) @(posedge hclk);
    hresetn <= 1'b1;
    @(posedge hclk);
    t_reset();
    t_table();
    t_modes();
    t_reserved();
    give_verdict();
  end
  initial begin
    #200000;
    hang();
  end
endmodule
